// *** rtl/capture_channel.sv ***
// Input capture channel with enable-time reinitialisation and register slave
`timescale 1ns/1ps
module capture_channel
    import capture_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic signal_in,
    input wire logic capture_in,
    input wire logic time_base_clk_in,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);

    pin_event_if ev ();

    pin_sync u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .signal_in(signal_in),
        .capture_in(capture_in),
        .time_base_clk_in(time_base_clk_in),
        .ev(ev)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Register slave

    logic [31:0] ctrl_r;
    logic [CNT_W-1:0] shadow_r;
    logic [CNT_W-1:0] running_counter_r, running_counter_nxt;
    logic [EDGE_EVENT_COUNTER_W-1:0] edge_event_counter_r, edge_event_counter_nxt;
    logic [CNT_W-1:0] capture_reg_a_r, capture_reg_a_nxt;
    logic [CNT_W-1:0] capture_reg_b_r, capture_reg_b_nxt;
    logic en_prev_r;

    logic aw_full_r, w_full_r;
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;

    // Write channel staging
    wire aw_take = awvalid & awready;
    wire w_take = wvalid & wready;
    wire have_aw = aw_full_r | aw_take;
    wire have_w = w_full_r | w_take;
    wire do_write = have_aw & have_w & ~bvalid;
    wire [7:0] wr_addr = aw_full_r ? aw_addr_r : awaddr;
    wire [31:0] wr_data = w_full_r ? w_data_r : wdata;
    wire [3:0] wr_strb = w_full_r ? w_strb_r : wstrb;
    wire [31:0] wr_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
    wire wr_ctrl = do_write & (wr_addr == CTRL_OFS);
    wire wr_shadow = do_write & (wr_addr == SHADOW_OFS);
    wire wr_known = wr_ctrl | wr_shadow;
    wire [31:0] ctrl_nxt = (ctrl_r & ~wr_mask) | (wr_data & wr_mask);
    wire [31:0] shadow_wide = {8'h00, shadow_r};
    wire [31:0] shadow_nxt = (shadow_wide & ~wr_mask) | (wr_data & wr_mask);
    wire aw_full_nxt = have_aw & ~do_write;
    wire w_full_nxt = have_w & ~do_write;
    wire bvalid_nxt = do_write | (bvalid & ~bready);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
        end else begin
            aw_full_r <= aw_full_nxt;
            w_full_r <= w_full_nxt;
            awready <= ~aw_full_nxt & ~bvalid_nxt;
            wready <= ~w_full_nxt & ~bvalid_nxt;
            bvalid <= bvalid_nxt;
            if (do_write) begin
                bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
            end
            if (aw_take) begin
                aw_addr_r <= awaddr;
            end
            if (w_take) begin
                w_data_r <= wdata;
                w_strb_r <= wstrb;
            end
        end
    end

    // Software-written control and shadow
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= CTRL_RST;
            shadow_r <= CNT_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= {27'h0, ctrl_nxt[4:0]};
            end
            if (wr_shadow) begin
                shadow_r <= shadow_nxt[CNT_W-1:0];
            end
        end
    end

    // Read channel and address decode
    wire ar_take = arvalid & arready;
    wire rvalid_nxt = ar_take | (rvalid & ~rready);
    wire rd_ctrl = (araddr == CTRL_OFS);
    wire rd_shadow = (araddr == SHADOW_OFS);
    wire rd_cnt = (araddr == COUNTER_OFS);
    wire rd_edge_event_counter = (araddr == EDGE_OFS);
    wire rd_capa = (araddr == CAPA_OFS);
    wire rd_capb = (araddr == CAPB_OFS);
    wire rd_known = rd_ctrl | rd_shadow | rd_cnt | rd_edge_event_counter | rd_capa | rd_capb;
    wire [31:0] rd_mux = rd_ctrl ? ctrl_r :
        rd_shadow ? {8'h00, shadow_r} :
        rd_cnt ? {8'h00, running_counter_r} :
        rd_edge_event_counter ? {16'h0000, edge_event_counter_r} :
        rd_capa ? {8'h00, capture_reg_a_r} :
        rd_capb ? {8'h00, capture_reg_b_r} : 32'h0000_0000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= RESP_OKAY;
        end else begin
            arready <= ~rvalid_nxt;
            rvalid <= rvalid_nxt;
            if (ar_take) begin
                rdata <= rd_mux;
                rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Channel core

    // Mode decode
    wire channel_enable_bit = ctrl_r[EN_BIT];
    wire ignore_level_setting = ctrl_r[ISL_BIT];
    wire [2:0] operating_mode_select = ctrl_r[MODE_LSB+2:MODE_LSB];
    wire edge_m = (operating_mode_select == input_edge_mode); // [R1]
    wire pres_m = (operating_mode_select == input_prescale_mode); // [R1]
    wire gps_m = (operating_mode_select == gated_periodic_sample_mode); // [R1]
    wire ssm_m = (operating_mode_select == serial_shift_mode); // [R1]
    wire plain_m = (operating_mode_select == pwm_measure_mode) |
        (operating_mode_select == pulse_integration_mode) |
        (operating_mode_select == bit_compression_mode); // [R2]
    wire reinit_m = edge_m | pres_m | gps_m; // [R2]
    wire en_rise = channel_enable_bit & ~en_prev_r;
    wire reset_now = en_rise & reinit_m; // [R3]
    wire init_now = en_rise & ssm_m; // [R7]

    // Starting point: reset or initial values instead of old contents
    wire serial_keep = ignore_level_setting | shadow_r[SHADOW_INIT_BIT];
    wire [CNT_W-1:0] ssm_init = serial_keep ? shadow_r : CNT_RST; // [R8]
    wire [CNT_W-1:0] cnt_base = reset_now ? CNT_RST :
        init_now ? ssm_init : running_counter_r; // [R4] [R7]
    wire [CNT_W-1:0] capa_base = (reset_now | init_now) ? CNT_RST : capture_reg_a_r; // [R3]
    wire [CNT_W-1:0] capb_base = (reset_now | init_now) ? CNT_RST : capture_reg_b_r; // [R3]
    wire [EDGE_EVENT_COUNTER_W-1:0] edge_event_counter_base = (reset_now | init_now) ?
        {15'h0000, edge_event_counter_r[0]} : edge_event_counter_r; // [R3] [R7]

    // Counting events per mode
    wire inc_evt = (gps_m | plain_m) ? ev.tb_tick : (edge_m | pres_m) & ev.in_edge; // [R6]
    wire [CNT_W-1:0] cnt_inc = cnt_base + 24'h00_0001;
    wire [CNT_W-1:0] cnt_step = inc_evt ? cnt_inc : cnt_base; // [R4]
    wire wrap_hit = (pres_m | gps_m) & inc_evt & (cnt_inc == shadow_r);
    wire plain_hit = plain_m & ev.in_edge;
    wire cap_take = ~ssm_m & (ev.cap_evt | (edge_m & ev.in_edge) | wrap_hit | plain_hit); // [R5]
    wire ssm_shift = ssm_m & ev.tb_tick & ~init_now; // [R9]
    wire edge_add = ev.in_edge & ~init_now; // [R9]

    always_comb begin
        running_counter_nxt = running_counter_r;
        edge_event_counter_nxt = edge_event_counter_r;
        capture_reg_a_nxt = capture_reg_a_r;
        capture_reg_b_nxt = capture_reg_b_r;
        if (channel_enable_bit) begin // [R10]
            edge_event_counter_nxt = edge_event_counter_base + {15'h0000, edge_add};
            capture_reg_a_nxt = cap_take ? cnt_step : capa_base; // [R5]
            capture_reg_b_nxt = cap_take ? capa_base : capb_base;
            if (ssm_m) begin
                running_counter_nxt = ssm_shift ?
                    {cnt_base[CNT_W-2:0], ev.in_level} : cnt_base;
            end else if (wrap_hit | plain_hit) begin
                running_counter_nxt = CNT_RST;
            end else begin
                running_counter_nxt = cnt_step; // [R4]
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            en_prev_r <= 1'b0;
            running_counter_r <= CNT_RST;
            edge_event_counter_r <= EDGE_EVENT_COUNTER_RST;
            capture_reg_a_r <= CNT_RST;
            capture_reg_b_r <= CNT_RST;
        end else begin
            en_prev_r <= channel_enable_bit;
            running_counter_r <= running_counter_nxt;
            edge_event_counter_r <= edge_event_counter_nxt;
            capture_reg_a_r <= capture_reg_a_nxt;
            capture_reg_b_r <= capture_reg_b_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence rise_reinit_s;
        en_rise && reinit_m;
    endsequence

    sequence rise_serial_s;
        en_rise && ssm_m;
    endsequence

    chk_reinit_clear: assert property ( // [R3]
        rise_reinit_s and !inc_evt && !ev.cap_evt |=> running_counter_r == 24'h00_0000 &&
        capture_reg_a_r == 24'h00_0000 && capture_reg_b_r == 24'h00_0000)
        else $error("enable did not reset counter and captures");

    chk_event_from_reset: assert property ( // [R4]
        rise_reinit_s and edge_m && ev.in_edge |=> running_counter_r == 24'h00_0001)
        else $error("coincident edge not counted from reset value");

    chk_capture_fresh: assert property ( // [R5]
        rise_reinit_s and ev.cap_evt && !inc_evt |=> capture_reg_a_r == 24'h00_0000)
        else $error("coincident capture not taken from fresh contents");

    chk_gated_tick: assert property ( // [R6]
        channel_enable_bit && !en_rise && gps_m && ev.tb_tick && !wrap_hit
        |=> running_counter_r == $past(running_counter_r) + 24'h00_0001)
        else $error("time-base tick not counted in gated sampling");

    chk_edge_count: assert property ( // [R1]
        channel_enable_bit && !en_rise && edge_m && ev.in_edge
        |=> running_counter_r == $past(running_counter_r) + 24'h00_0001 &&
        capture_reg_a_r == running_counter_r)
        else $error("input edge mode did not count and capture");

    chk_serial_zero: assert property ( // [R8]
        rise_serial_s and !ignore_level_setting && !shadow_r[SHADOW_INIT_BIT]
        |=> running_counter_r == 24'h00_0000)
        else $error("serial shift counter did not start at zero");

    chk_serial_ignore: assert property ( // [R9] [R7]
        rise_serial_s |=> edge_event_counter_r == {15'h0000, $past(edge_event_counter_r[0])}
        && capture_reg_a_r == 24'h00_0000)
        else $error("serial shift took event at enable");

    chk_plain_keep: assert property ( // [R2]
        en_rise && plain_m && !ev.tb_tick && !ev.in_edge && !ev.cap_evt
        |=> $stable(running_counter_r) && $stable(capture_reg_a_r))
        else $error("plain mode reinitialised on enable");

    chk_disabled_hold: assert property ( // [R10]
        !channel_enable_bit |=> $stable(running_counter_r) && $stable(edge_event_counter_r)
        && $stable(capture_reg_b_r))
        else $error("disabled channel changed state");

endmodule

// *** rtl/capture_pkg.sv ***
// Shared constants and types for the input capture channel
//
// Contract
// [R1] Codes 010, 011, 101, 110 select four modes
// [R2] Codes 000, 001, 100 skip enable reinitialisation
// [R3] Enable resets counter, edge count upper, captures
// [R4] Coincident event counts from reset counter value
// [R5] Coincident event may capture from fresh contents
// [R6] Gated sampling counts time-base clock edges
// [R7] Serial shift enable loads mode initial values
// [R8] Serial counter start from ignore level, shadow bit
// [R9] Serial shift ignores event at enable
// [R10] Disabled channel holds all counters and captures
package capture_pkg;

    typedef enum logic [2:0] {
        pwm_measure_mode = 3'h0,
        pulse_integration_mode = 3'h1,
        input_edge_mode = 3'h2,
        input_prescale_mode = 3'h3,
        bit_compression_mode = 3'h4,
        gated_periodic_sample_mode = 3'h5,
        serial_shift_mode = 3'h6,
        spare_mode = 3'h7
    } mode_e;

    localparam int CNT_W = 24;
    localparam int EDGE_EVENT_COUNTER_W = 16;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] SHADOW_OFS = 8'h04;
    localparam logic [7:0] COUNTER_OFS = 8'h08;
    localparam logic [7:0] EDGE_OFS = 8'h0c;
    localparam logic [7:0] CAPA_OFS = 8'h10;
    localparam logic [7:0] CAPB_OFS = 8'h14;

    // Control register fields, and the shadow register init bit
    localparam int EN_BIT = 0;
    localparam int MODE_LSB = 1;
    localparam int ISL_BIT = 4;
    localparam int SHADOW_INIT_BIT = 22;

    // Reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [CNT_W-1:0] CNT_RST = 24'h00_0000;
    localparam logic [EDGE_EVENT_COUNTER_W-1:0] EDGE_EVENT_COUNTER_RST = 16'h0000;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// *** rtl/pin_event_if.sv ***
// Synchronised pin events passed from the pin front end to the channel
`timescale 1ns/1ps
interface pin_event_if;
    logic in_level;
    logic in_edge;
    logic cap_evt;
    logic tb_tick;
    modport src (output in_level, output in_edge, output cap_evt, output tb_tick);
    modport dst (input in_level, input in_edge, input cap_evt, input tb_tick);
endinterface

// *** rtl/pin_sync.sv ***
// Two-stage synchronisers and edge detection for the channel pins
`timescale 1ns/1ps
module pin_sync
    import capture_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic signal_in,
    input wire logic capture_in,
    input wire logic time_base_clk_in,
    pin_event_if.src ev
);

    localparam int N = 3;

    logic [N-1:0] pins;
    logic [N-1:0] meta_r;
    logic [N-1:0] sync_r;
    logic [N-1:0] last_r;

    assign pins = {time_base_clk_in, capture_in, signal_in};

    // One synchroniser chain per pin
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_sync
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    meta_r[g] <= 1'b0;
                    sync_r[g] <= 1'b0;
                    last_r[g] <= 1'b0;
                end else begin
                    meta_r[g] <= pins[g];
                    sync_r[g] <= meta_r[g];
                    last_r[g] <= sync_r[g];
                end
            end
        end
    endgenerate

    // Input edges both ways, capture and tick on rising edge
    assign ev.in_level = sync_r[0];
    assign ev.in_edge = sync_r[0] ^ last_r[0];
    assign ev.cap_evt = sync_r[1] & ~last_r[1];
    assign ev.tb_tick = sync_r[2] & ~last_r[2];

endmodule

// *** testbench/pin_partner.sv ***
// Behavioural model of the pins driven from outside the channel
`timescale 1ns/1ps
module pin_partner (
    input wire logic aclk,
    output logic signal_in,
    output logic capture_in,
    output logic time_base_clk_in
);
    // Pins idle low, time base stands still outside requested ticks
    initial begin
        signal_in = 1'b0;
        capture_in = 1'b0;
        time_base_clk_in = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // One level change, held long enough for the synchronisers
    task automatic toggle_signal();
        @(posedge aclk);
        signal_in <= ~signal_in;
        repeat (3) @(posedge aclk);
    endtask

    // One time-base period: high two cycles, low two cycles
    task automatic tick();
        @(posedge aclk);
        time_base_clk_in <= 1'b1;
        repeat (2) @(posedge aclk);
        time_base_clk_in <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask

    // One capture pin pulse: high two cycles, low two cycles
    task automatic capture_pulse();
        @(posedge aclk);
        capture_in <= 1'b1;
        repeat (2) @(posedge aclk);
        capture_in <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask
endmodule

// *** testbench/tb_top.sv ***
// Self-checking bench for the capture channel over its register bus
`timescale 1ns/1ps
module tb_top
    import capture_pkg::*;
;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, r;
    logic signal_in, capture_in, time_base_clk_in;
    logic [31:0] sh [3] = '{32'h0000_0003, 32'h0040_0005, 32'h0000_0007};
    logic [31:0] cdis [3] = '{32'h0000_000c, 32'h0000_000c, 32'h0000_001c};
    int fails, checks_done, cycles;

    capture_channel capture_channel_inst (.aclk(aclk), .aresetn(aresetn),
        .signal_in(signal_in), .capture_in(capture_in), .time_base_clk_in(time_base_clk_in),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

    pin_partner pin_partner_inst (.aclk(aclk), .signal_in(signal_in),
        .capture_in(capture_in), .time_base_clk_in(time_base_clk_in));

    ////////////////////////////////////////////////////////////////////////
    // Clock and hang guard
    always #50 aclk = ~aclk;

    always @(posedge aclk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            fails = fails + 1;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Verdict and comparison
    task automatic results();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Write: address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        rs = bresp;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        v = rdata;
        rs = rresp;
    endtask

    // Read one register, compare value and an OKAY response
    task automatic expect_reg(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        logic [1:0] rs;
        rd(a, v, rs);
        check(v, exp);
        check({30'h0, rs}, {30'h0, RESP_OKAY});
    endtask

    task automatic settle();
        repeat (6) @(posedge aclk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0000_0000;
        wstrb = 4'hf;
        fails = 0;
        checks_done = 0;
        cycles = 0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        expect_reg(CTRL_OFS, 32'h0000_0000);
        expect_reg(COUNTER_OFS, 32'h0000_0000);
        rd(8'h18, d, r);
        check(d, 32'h0000_0000);
        check({30'h0, r}, {30'h0, RESP_SLVERR});
        wr(8'h18, 32'h0000_00ff, r);
        check({30'h0, r}, {30'h0, RESP_SLVERR});
        $display("test reset done");
        // Edge mode counts and captures each input edge
        wr(CTRL_OFS, 32'h0000_0005, r);
        repeat (3) pin_partner_inst.toggle_signal();
        settle();
        expect_reg(COUNTER_OFS, 32'h0000_0003);
        expect_reg(CAPA_OFS, 32'h0000_0003);
        expect_reg(CAPB_OFS, 32'h0000_0002);
        wr(CTRL_OFS, 32'h0000_0004, r);
        repeat (2) pin_partner_inst.toggle_signal();
        settle();
        expect_reg(COUNTER_OFS, 32'h0000_0003);
        expect_reg(EDGE_OFS, 32'h0000_0003);
        // Re-enable with an input edge landing on the enable
        fork
            pin_partner_inst.toggle_signal();
            begin
                @(posedge aclk); // Pin leads so its event meets the enable rise
                wr(CTRL_OFS, 32'h0000_0005, r);
            end
        join
        settle();
        expect_reg(COUNTER_OFS, 32'h0000_0001);
        expect_reg(CAPA_OFS, 32'h0000_0001);
        expect_reg(CAPB_OFS, 32'h0000_0000);
        expect_reg(EDGE_OFS, 32'h0000_0002);
        $display("test edge mode done");
        // Gated sampling counts ticks, captures and restarts at compare
        wr(SHADOW_OFS, 32'h0000_0003, r);
        wr(CTRL_OFS, 32'h0000_000a, r);
        wr(CTRL_OFS, 32'h0000_000b, r);
        repeat (3) pin_partner_inst.tick();
        settle();
        expect_reg(COUNTER_OFS, 32'h0000_0000);
        expect_reg(CAPA_OFS, 32'h0000_0003);
        expect_reg(CAPB_OFS, 32'h0000_0000);
        $display("test gated mode done");
        // Measurement mode keeps its counter over disable and enable
        wr(CTRL_OFS, 32'h0000_0000, r);
        wr(CTRL_OFS, 32'h0000_0001, r);
        repeat (2) pin_partner_inst.tick();
        settle();
        expect_reg(COUNTER_OFS, 32'h0000_0002);
        wr(CTRL_OFS, 32'h0000_0000, r);
        wr(CTRL_OFS, 32'h0000_0001, r);
        settle();
        expect_reg(COUNTER_OFS, 32'h0000_0002);
        // Bit compression, then pulse integration: no reinit either
        wr(CTRL_OFS, 32'h0000_0008, r);
        wr(CTRL_OFS, 32'h0000_0009, r);
        wr(CTRL_OFS, 32'h0000_0002, r);
        wr(CTRL_OFS, 32'h0000_0003, r);
        settle();
        expect_reg(COUNTER_OFS, 32'h0000_0002);
        $display("test no reinit done");
        // Serial shift start value from ignore level and shadow bit 22
        for (int i = 0; i < 3; i++) begin
            wr(SHADOW_OFS, sh[i], r);
            wr(CTRL_OFS, cdis[i], r);
            fork
                pin_partner_inst.toggle_signal();
                begin
                    @(posedge aclk); // Input edge lands on the enable rise
                    wr(CTRL_OFS, cdis[i] | 32'h0000_0001, r);
                end
            join
            settle();
            expect_reg(COUNTER_OFS, (i == 0) ? 32'h0000_0000 : sh[i]);
            expect_reg(CAPA_OFS, 32'h0000_0000);
            expect_reg(CAPB_OFS, 32'h0000_0000);
            expect_reg(EDGE_OFS, 32'h0000_0000);
        end
        $display("test serial mode done");
        // Prescale restarts at compare, capture pin on enable takes fresh zero
        wr(SHADOW_OFS, 32'h0000_0002, r);
        wr(CTRL_OFS, 32'h0000_0006, r);
        wr(CTRL_OFS, 32'h0000_0007, r);
        repeat (3) pin_partner_inst.toggle_signal();
        pin_partner_inst.capture_pulse();
        settle();
        expect_reg(COUNTER_OFS, 32'h0000_0001);
        expect_reg(CAPA_OFS, 32'h0000_0001);
        expect_reg(CAPB_OFS, 32'h0000_0002);
        wr(CTRL_OFS, 32'h0000_0006, r);
        fork
            pin_partner_inst.capture_pulse();
            begin
                @(posedge aclk); // Capture event lands on the enable rise
                wr(CTRL_OFS, 32'h0000_0007, r);
            end
        join
        settle();
        expect_reg(COUNTER_OFS, 32'h0000_0000);
        expect_reg(CAPA_OFS, 32'h0000_0000);
        expect_reg(CAPB_OFS, 32'h0000_0000);
        expect_reg(EDGE_OFS, 32'h0000_0001);
        $display("test prescale mode done");
        results();
    end
endmodule
